// ==== hdl/aof_formatter.sv ====
// Function
// - forwarded clock quarter rate demuxed, half otherwise
// - both buses launched with forwarded clock
// - I and Q forwarded clocks stay in phase
// - range flag high while input beyond full scale
// - range flag leaves with its own word
// - non-demuxed: one word per sample, later bus
// - demuxed later bus carries second sample of pair
// - non-demuxed mode: earlier buses high impedance
// - demuxed earlier bus carries first sample of pair
// - demuxed only: phase select offsets clock mid-data
// - power-down high stops channel; low resumes later
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// simple synchronous fifo, honest full and empty
module aof_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    // storage array
    logic [WIDTH-1:0] mem [DEPTH];
    // pointers carry one extra wrap bit
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    logic push;
    logic pop;

    assign inReady = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    // read word straight from the array, it sits still while waiting
    assign outData = mem[rdPtr_reg[AW-1:0]];

    // write port, no reset needed on the data array
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    // pointer update
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end
        else
        begin
            if (push)
                wrPtr_reg <= wrPtr_reg + 1'b1;
            if (pop)
                rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// output formatter: sampling clock in, lvds style buses and forwarded clocks out
module aof_formatter #(
    parameter int SAMPLE_W = aof_pkg::SAMPLE_WIDTH,
    parameter int DEPTH = aof_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // converter side, timed by the sampling clock
    input wire logic sampleClock,
    input wire logic [SAMPLE_W-1:0] iSampleIn,
    input wire logic [SAMPLE_W-1:0] qSampleIn,
    input wire logic iOverRangeIn,
    input wire logic qOverRangeIn,
    output logic sampleReady,
    // control pins
    input wire logic demuxSelectPin,
    input wire logic clockPhaseSelect,
    input wire logic iPowerDown,
    input wire logic qPowerDown,
    // forwarded clocks and range flags
    output logic iForwardedClock,
    output logic qForwardedClock,
    output logic iRangeFlag,
    output logic qRangeFlag,
    // later buses
    output logic [SAMPLE_W-1:0] iLaterBus,
    output logic [SAMPLE_W-1:0] qLaterBus,
    // earlier buses, three-state
    output logic [SAMPLE_W-1:0] iEarlierBus,
    output logic iEarlierBusOe,
    output logic [SAMPLE_W-1:0] qEarlierBus,
    output logic qEarlierBusOe
);
    import aof_pkg::*;

    localparam int PW = 2 * (SAMPLE_W + 1);

    // two-stage synchronisers, stage one is read only by stage two
    logic [PW+4:0] syncA_reg;
    logic [PW+4:0] syncB_reg;
    // previous sampling clock level for edge finding
    logic sclkLast_reg;
    logic sclkFall;
    aof_pair_s inPair;
    aof_pair_s popPair;
    logic popValid;
    logic popReady;
    // channel run state, index 0 is I and 1 is Q
    logic [1:0] active_reg;
    logic [10:0] wakeCnt_reg [2];
    logic [1:0] pdSync;
    // formatter state
    aof_fmt_e state_reg;
    logic [7:0] slotCnt_reg;
    logic demuxMode_reg;
    logic clkPhase_reg;
    aof_pair_s early_reg;
    logic launch;
    logic phase90;
    logic toggleNow;
    // output registers
    logic [SAMPLE_W-1:0] iLater_reg, qLater_reg, iEarly_reg, qEarly_reg;
    logic iFlag_reg, qFlag_reg;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation: everything here comes from outside core_clk
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            syncA_reg <= '0;
            syncB_reg <= '0;
            sclkLast_reg <= 1'b0;
        end
        else
        begin
            syncA_reg <= {sampleClock, demuxSelectPin, clockPhaseSelect, iPowerDown, qPowerDown,
                          iOverRangeIn, iSampleIn, qOverRangeIn, qSampleIn};
            syncB_reg <= syncA_reg;
            sclkLast_reg <= syncB_reg[PW+4];
        end
    end

    // capture on the falling edge, mid-period, where the word is settled
    assign sclkFall = sclkLast_reg && !syncB_reg[PW+4];
    assign inPair = aof_pair_s'(syncB_reg[PW-1:0]);
    assign pdSync = syncB_reg[PW+1:PW];

    ////////////////////////////////////////////////////////////////////////////
    // sample buffer; a full fifo drops the word and shows sampleReady low
    aof_fifo #(
        .WIDTH(PW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .inValid(sclkFall),
        .inReady(sampleReady),
        .inData(inPair),
        .outValid(popValid),
        .outReady(popReady),
        .outData(popPair)
    );

    ////////////////////////////////////////////////////////////////////////////
    // power-down per channel, with a settle delay on the way back up
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            active_reg <= 2'b00;
            wakeCnt_reg[0] <= WAKE_COUNT_RESET;
            wakeCnt_reg[1] <= WAKE_COUNT_RESET;
        end
        else
        begin
            for (int ch = 0; ch < 2; ch++)
            begin
                if (pdSync[1-ch])
                begin
                    active_reg[ch] <= 1'b0;
                    wakeCnt_reg[ch] <= WAKE_COUNT_RESET;
                end
                else if (!active_reg[ch])
                begin
                    // the channel rejoins only after the full settle time
                    if (wakeCnt_reg[ch] == 11'(WAKE_CYC - 1))
                        active_reg[ch] <= 1'b1;
                    else
                        wakeCnt_reg[ch] <= wakeCnt_reg[ch] + 11'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pairing and pacing state machine
    // pop only while waiting for a word; the hold slot stalls the fifo
    assign popReady = (state_reg == FMT_WAIT) || (state_reg == FMT_PAIR);
    // one word per launch when not demuxed
    assign launch = popValid && ((state_reg == FMT_PAIR) || (state_reg == FMT_WAIT && !demuxMode_reg));
    // offset only counts in demuxed mode
    assign phase90 = syncB_reg[PW+2] && demuxMode_reg;
    // clock edge tied to the launch, at once or half a slot later
    assign toggleNow = (launch && !phase90)
                     || (state_reg == FMT_HOLD && phase90 && slotCnt_reg == 8'(PHASE_OFFSET_CYC - 1));

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= FMT_WAIT;
            slotCnt_reg <= SLOT_COUNT_RESET;
            demuxMode_reg <= 1'b0;
            early_reg <= '0;
        end
        else
        begin
            case (state_reg)
                FMT_WAIT:
                begin
                    // mode only changes between pairs; pin low means demuxed
                    demuxMode_reg <= !syncB_reg[PW+3];
                    slotCnt_reg <= SLOT_COUNT_RESET;
                    if (popValid && demuxMode_reg)
                    begin
                        // first sample of a pair is kept for the earlier bus
                        early_reg <= popPair;
                        state_reg <= FMT_PAIR;
                    end
                    else if (launch)
                        state_reg <= FMT_HOLD;
                end
                FMT_PAIR:
                begin
                    slotCnt_reg <= SLOT_COUNT_RESET;
                    if (launch)
                        state_reg <= FMT_HOLD;
                end
                FMT_HOLD:
                begin
                    // launch cycle plus hold spans exactly one slot
                    // a longer hold would fall behind the sample rate and overrun the fifo
                    if (slotCnt_reg == 8'(SLOT_CYC - 2))
                        state_reg <= FMT_WAIT;
                    else
                        slotCnt_reg <= slotCnt_reg + 8'h01;
                end
                default:
                    state_reg <= FMT_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared clock phase: one toggle per launch halves the word rate
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            clkPhase_reg <= 1'b0;
        // one edge per word or per pair gives half or quarter rate
        else if (toggleNow)
            clkPhase_reg <= !clkPhase_reg;
    end

    // both clocks gate one common phase, so no alignment pulse exists
    assign iForwardedClock = clkPhase_reg && active_reg[0];
    assign qForwardedClock = clkPhase_reg && active_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // output word registers, loaded with zero at each launch while a channel is down
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            iLater_reg <= CODE_RESET;
            qLater_reg <= CODE_RESET;
            iEarly_reg <= CODE_RESET;
            qEarly_reg <= CODE_RESET;
            iFlag_reg <= 1'b0;
            qFlag_reg <= 1'b0;
        end
        else if (launch)
        begin
            // later bus takes the word just popped
            iLater_reg <= active_reg[0] ? popPair.iSample.code : CODE_RESET;
            qLater_reg <= active_reg[1] ? popPair.qSample.code : CODE_RESET;
            iEarly_reg <= active_reg[0] ? early_reg.iSample.code : CODE_RESET;
            qEarly_reg <= active_reg[1] ? early_reg.qSample.code : CODE_RESET;
            // flag follows the input condition of the words it goes out with
            // loaded in the same launch as the words
            iFlag_reg <= active_reg[0] && (popPair.iSample.overRange || (demuxMode_reg && early_reg.iSample.overRange));
            qFlag_reg <= active_reg[1] && (popPair.qSample.overRange || (demuxMode_reg && early_reg.qSample.overRange));
        end
    end

    // same twelve bit order on every bus
    assign iLaterBus = iLater_reg;
    assign qLaterBus = qLater_reg;
    assign iEarlierBus = iEarly_reg;
    assign qEarlierBus = qEarly_reg;
    assign iRangeFlag = iFlag_reg;
    assign qRangeFlag = qFlag_reg;
    assign iEarlierBusOe = demuxMode_reg && active_reg[0];
    assign qEarlierBusOe = demuxMode_reg && active_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_earlyHiz;
        @(posedge core_clk) disable iff (reset) !demuxMode_reg |-> !iEarlierBusOe && !qEarlierBusOe;
    endproperty
    a_earlyHiz: assert property (p_earlyHiz) else $error("earlier bus driven outside demux");

    property p_inPhase;
        @(posedge core_clk) disable iff (reset) (active_reg == 2'b11) |-> iForwardedClock == qForwardedClock;
    endproperty
    a_inPhase: assert property (p_inPhase) else $error("forwarded clocks out of phase");

    property p_toggle0;
        @(posedge core_clk) disable iff (reset) launch && !phase90 |=> clkPhase_reg != $past(clkPhase_reg);
    endproperty
    a_toggle0: assert property (p_toggle0) else $error("clock did not move with launch");

    property p_toggle90;
        @(posedge core_clk) disable iff (reset)
            launch && phase90 |=> (clkPhase_reg == $past(clkPhase_reg)) ##5 $changed(clkPhase_reg);
    endproperty
    a_toggle90: assert property (p_toggle90) else $error("90 degree edge misplaced");

    property p_spacing;
        @(posedge core_clk) disable iff (reset) launch |=> !launch [*8];
    endproperty
    a_spacing: assert property (p_spacing) else $error("words launched too close");

    property p_flag;
        @(posedge core_clk) disable iff (reset)
            launch && !demuxMode_reg |=> iRangeFlag == $past(popPair.iSample.overRange && active_reg[0]);
    endproperty
    a_flag: assert property (p_flag) else $error("range flag not with its word");

    property p_pairOrder;
        @(posedge core_clk) disable iff (reset) launch && demuxMode_reg && active_reg[0]
            |=> iEarlierBus == $past(early_reg.iSample.code) && iLaterBus == $past(popPair.iSample.code);
    endproperty
    a_pairOrder: assert property (p_pairOrder) else $error("pair order wrong");

    property p_wake;
        @(posedge core_clk) disable iff (reset) $fell(pdSync[1]) |-> !active_reg[0] [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("channel woke too early");

    property p_wakeQ;
        @(posedge core_clk) disable iff (reset) $fell(pdSync[0]) |-> !active_reg[1] [*8];
    endproperty
    a_wakeQ: assert property (p_wakeQ) else $error("q channel woke too early");
endmodule

`default_nettype wire

// ==== hdl/aof_pkg.sv ====
package aof_pkg;
    // sample word width and output bit order, bit 11 is the msb
    localparam int SAMPLE_WIDTH = 12;
    // core clock period in ns
    localparam int CORE_CLK_NS = 8;
    // half of a sample period: the 90 degree clock offset in demuxed mode
    localparam int PHASE_OFFSET_NS = 40;
    // longest time, so it rounds down, never below one cycle
    localparam int PHASE_OFFSET_CYC = (PHASE_OFFSET_NS / CORE_CLK_NS) < 1 ? 1 : (PHASE_OFFSET_NS / CORE_CLK_NS);
    // an output slot spans two phase offsets
    localparam int SLOT_CYC = 2 * PHASE_OFFSET_CYC;
    // least settle time after a power-down release, rounded up
    localparam int WAKE_NS = 1000;
    localparam int WAKE_CYC = (WAKE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    // fifo defaults
    localparam int FIFO_DEPTH = 16;
    // reset values
    localparam logic [SAMPLE_WIDTH-1:0] CODE_RESET = 12'h000;
    localparam logic [7:0] SLOT_COUNT_RESET = 8'h00;
    localparam logic [10:0] WAKE_COUNT_RESET = 11'h000;

    // one converted sample with its over-range status
    typedef struct packed {
        logic overRange;
        logic [SAMPLE_WIDTH-1:0] code;
    } aof_sample_s;

    // one conversion instant for both channels
    typedef struct packed {
        aof_sample_s iSample;
        aof_sample_s qSample;
    } aof_pair_s;

    // output formatter states
    typedef enum logic [1:0] {
        FMT_WAIT,
        FMT_PAIR,
        FMT_HOLD
    } aof_fmt_e;
endpackage

// ==== tb/aof_capture_rx.sv ====
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// capture receiver: latches both channels on every edge of the I forwarded clock
module aof_capture_rx
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // forwarded clocks
    input wire logic iFwdClk,
    input wire logic qFwdClk,
    // range flags and later buses
    input wire logic iFlag,
    input wire logic qFlag,
    input wire logic [aof_pkg::SAMPLE_WIDTH-1:0] iLater,
    input wire logic [aof_pkg::SAMPLE_WIDTH-1:0] qLater,
    // earlier buses with their enables
    input wire logic [aof_pkg::SAMPLE_WIDTH-1:0] iEarlier,
    input wire logic iEarlierOe,
    input wire logic [aof_pkg::SAMPLE_WIDTH-1:0] qEarlier,
    input wire logic qEarlierOe
);
    import aof_pkg::*;
    // captured later words, oldest first
    aof_pair_s laterQ[$];
    // earlier words; the overRange field holds the enable seen
    aof_pair_s earlierQ[$];
    // cycles from the last data change to each clock edge
    int lag[$];
    int skewCount;
    int sinceChange;
    logic iClkPrev;
    logic [SAMPLE_WIDTH-1:0] iLaterPrev, iWireLast, qWireLast, iWire, qWire;

    // a released bus flips every cycle, so a stale copy never passes
    assign iWire = iEarlierOe ? iEarlier : ~iWireLast;
    assign qWire = qEarlierOe ? qEarlier : ~qWireLast;

    // edge detect on the forwarded clock; both edges carry a word
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            skewCount <= 0;
            sinceChange <= 0;
            iClkPrev <= 1'b0;
            iLaterPrev <= '0;
            iWireLast <= '0;
            qWireLast <= '0;
        end
        else
        begin
            iWireLast <= iWire;
            qWireLast <= qWire;
            iClkPrev <= iFwdClk;
            iLaterPrev <= iLater;
            sinceChange <= (iLater != iLaterPrev) ? 0 : sinceChange + 1;
            // count cycles where the two clocks disagree
            if (iFwdClk != qFwdClk)
                skewCount <= skewCount + 1;
            if (iFwdClk != iClkPrev)
            begin
                laterQ.push_back({iFlag, iLater, qFlag, qLater});
                earlierQ.push_back({iEarlierOe, iWire, qEarlierOe, qWire});
                lag.push_back((iLater != iLaterPrev) ? 0 : sinceChange + 1);
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb/aof_formatter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module aof_formatter_tb;
    import aof_pkg::*;
    // stimulus and observed outputs
    logic core_clk, reset, sampleClock, sampleReady, seenFull;
    logic [SAMPLE_WIDTH-1:0] iSampleIn, qSampleIn, iLaterBus, qLaterBus, iEarlierBus, qEarlierBus;
    logic iOverRangeIn, qOverRangeIn, demuxSelectPin, clockPhaseSelect, iPowerDown, qPowerDown;
    logic iForwardedClock, qForwardedClock, iRangeFlag, qRangeFlag, iEarlierBusOe, qEarlierBusOe;
    int n_fail, samples_checked, skewSnap;
    // core cycles per half sampling period, 5 gives the 80 ns clock
    int halfCycles;

    // 125 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    aof_formatter i_dut (.core_clk, .reset, .sampleClock, .iSampleIn, .qSampleIn, .iOverRangeIn,
        .qOverRangeIn, .sampleReady, .demuxSelectPin, .clockPhaseSelect, .iPowerDown, .qPowerDown,
        .iForwardedClock, .qForwardedClock, .iRangeFlag, .qRangeFlag, .iLaterBus, .qLaterBus,
        .iEarlierBus, .iEarlierBusOe, .qEarlierBus, .qEarlierBusOe);

    aof_capture_rx i_rx (.core_clk(core_clk), .reset(reset), .iFwdClk(iForwardedClock),
        .qFwdClk(qForwardedClock), .iFlag(iRangeFlag), .qFlag(qRangeFlag), .iLater(iLaterBus),
        .qLater(qLaterBus), .iEarlier(iEarlierBus), .iEarlierOe(iEarlierBusOe),
        .qEarlier(qEarlierBus), .qEarlierOe(qEarlierBusOe));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and comparison
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // half a sample period, noting any refusal by the fifo
    task automatic half;
        repeat (halfCycles)
        begin
            @(negedge core_clk);
            if (sampleReady === 1'b0)
                seenFull = 1'b1;
        end
    endtask

    // sampling clock, 80 ns at halfCycles 5, data set at its rise, captured at its fall
    task automatic send(input int n, input int base, input logic [15:0] ovr);
        for (int k = 0; k < n; k++)
        begin
            iSampleIn = 12'(base + k);
            qSampleIn = 12'hFFF - iSampleIn;
            iOverRangeIn = ovr[k % 8];
            qOverRangeIn = ovr[8 + k % 8];
            sampleClock = 1'b1;
            half();
            sampleClock = 1'b0;
            half();
        end
    endtask

    // bounded wait for n captured words, then let the hold run out
    task automatic drain(input int n);
        int t;
        t = 0;
        while (i_rx.laterQ.size() < n && t < 300 * n + 300)
        begin
            @(negedge core_clk);
            t++;
        end
        if (i_rx.laterQ.size() < n)
        begin
            n_fail++;
            $display("BAD drain expected %0d seen %0d", n, i_rx.laterQ.size());
            give_verdict();
        end
        repeat (20) @(negedge core_clk);
    endtask

    // pick the mode while idle and empty the receiver
    task automatic start(input logic nonDemux, input logic phase);
        demuxSelectPin = nonDemux;
        clockPhaseSelect = phase;
        repeat (6) @(negedge core_clk);
        i_rx.laterQ.delete();
        i_rx.earlierQ.delete();
        i_rx.lag.delete();
        skewSnap = i_rx.skewCount;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one word per edge on the later bus, earlier bus released
    task automatic t_nondemux;
        aof_pair_s l, e;
        start(1'b1, 1'b0);
        send(6, 'h100, 16'h2124);
        drain(6);
        check("words", i_rx.laterQ.size(), 6);
        for (int k = 0; k < 6; k++)
        begin
            l = i_rx.laterQ[k];
            e = i_rx.earlierQ[k];
            check("iLater", l.iSample.code, 12'(256 + k));
            check("qLater", l.qSample.code, 12'hFFF - 12'(256 + k));
            check("iFlag", l.iSample.overRange, 16'h2124 >> k & 1);
            check("qFlag", l.qSample.overRange, 16'h2124 >> (8 + k) & 1);
            check("iOe", e.iSample.overRange, 0);
            check("qOe", e.qSample.overRange, 0);
        end
        check("skew", i_rx.skewCount, skewSnap);
    endtask

    // pairs: earlier word first sample, later word second, one edge each
    task automatic t_demux(input logic phase);
        aof_pair_s l, e;
        int a;
        start(1'b0, phase);
        send(8, 'h200, 16'h4018);
        drain(4);
        check("pairs", i_rx.laterQ.size(), 4);
        for (int p = 0; p < 4; p++)
        begin
            a = 512 + 2 * p;
            l = i_rx.laterQ[p];
            e = i_rx.earlierQ[p];
            check("iEarly", e.iSample.code, 12'(a));
            check("qEarly", e.qSample.code, 12'hFFF - 12'(a));
            check("iLate", l.iSample.code, 12'(a + 1));
            check("qLate", l.qSample.code, 12'hFFF - 12'(a + 1));
            check("iFlag", l.iSample.overRange, (16'h4018 >> 2 * p & 3) != 0);
            check("qFlag", l.qSample.overRange, (16'h4018 >> (8 + 2 * p) & 3) != 0);
            check("oe", e.iSample.overRange & e.qSample.overRange, 1);
            check("phase", i_rx.lag[p] != 0, phase);
        end
        check("skew", i_rx.skewCount, skewSnap);
    endtask

    // q channel down, then back after its wake delay
    task automatic t_power;
        qPowerDown = 1'b1;
        start(1'b1, 1'b0);
        send(3, 'h300, 16'hFF00);
        drain(3);
        for (int k = 0; k < 3; k++)
        begin
            check("iCode", i_rx.laterQ[k].iSample.code, 12'(768 + k));
            check("qDown", i_rx.laterQ[k], {1'b0, 12'(768 + k), 13'h0000});
        end
        check("qClk", qForwardedClock, 0);
        qPowerDown = 1'b0;
        start(1'b1, 1'b0);
        send(1, 'h310, 16'hFF00);
        drain(1);
        check("qWaking", i_rx.laterQ[0].qSample, 0);
        repeat (WAKE_CYC) @(negedge core_clk);
        start(1'b1, 1'b0);
        send(1, 'h320, 16'hFF00);
        drain(1);
        check("qAwake", i_rx.laterQ[0].qSample, {1'b1, 12'hFFF - 12'h320});
    endtask

    // overrun the fifo with a sampling clock faster than the output pace, then let it drain empty
    task automatic t_fill;
        start(1'b1, 1'b0);
        seenFull = 1'b0;
        halfCycles = 3;
        send(200, 0, 16'h0000);
        halfCycles = 5;
        check("full", seenFull, 1);
        repeat (16 * 12 + 40) @(negedge core_clk);
        check("ready", sampleReady, 1);
        check("drops", i_rx.laterQ.size() < 200, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        reset = 1'b1;
        sampleClock = 1'b0;
        iSampleIn = 12'h000;
        qSampleIn = 12'h000;
        iOverRangeIn = 1'b0;
        qOverRangeIn = 1'b0;
        demuxSelectPin = 1'b1;
        clockPhaseSelect = 1'b0;
        iPowerDown = 1'b0;
        qPowerDown = 1'b0;
        seenFull = 1'b0;
        halfCycles = 5;
        n_fail = 0;
        samples_checked = 0;
        repeat (4) @(negedge core_clk);
        check("rstBus", {iLaterBus, iEarlierBusOe, iForwardedClock, iRangeFlag}, 0);
        reset = 1'b0;
        repeat (WAKE_CYC + 12) @(negedge core_clk);
        check("rdy", sampleReady, 1);
        t_nondemux();
        t_demux(1'b0);
        t_demux(1'b1);
        t_power();
        t_fill();
        give_verdict();
    end
endmodule

`default_nettype wire
